// [rtl/afs_adc_fifo_sequencer.sv]
// Conversion sequencer, result queue and host read port
`timescale 1ns/1ps
module afs_adc_fifo_sequencer (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Conversion start pin and comparator
    input  wire logic                        convStartN,
    input  wire logic                        compBit,
    // Host bus, same clock source
    input  wire afs_pkg::afs_host_t          hostBus,
    // Converter outputs
    output logic                             busyN,
    output logic                             sampleHold,
    output logic [afs_pkg::DATA_W-1:0]       dacCode,
    // Host data and flags
    output logic [afs_pkg::DATA_W-1:0]       dataOut,
    output logic                             dataOe,
    output logic                             queueEmptyFlag,
    output logic                             almostFullN
);

    typedef struct packed {
        afs_pkg::afs_state_t                     st;
        logic [1:0]                              phase;
        logic [3:0]                              bitIdx;
        logic [afs_pkg::DATA_W-1:0]              sar;
        logic                                    oorBit;
        logic                                    busyN;
        logic                                    hold;
        logic                                    prevStart;
        logic [3:0]                              count;
        logic                                    empty;
        afs_pkg::afs_entry_t [afs_pkg::QUEUE_DEPTH-1:0] queue;
        logic                                    rdActPrev;
        logic [2:0]                              afc;
        logic                                    enaf;
        logic                                    ovr;
        logic                                    holdoff;
        logic                                    alflN;
        logic [afs_pkg::DATA_W-1:0]              dataOut;
        logic                                    dataOe;
    } afs_regs_t;

    afs_regs_t r_q;
    afs_regs_t r_d;
    logic      startS;
    logic      busAct;
    logic      readAct;
    logic      readDone;
    logic      push;
    logic      startFall;
    logic      startRise;
    logic [2:0] fcn;
    logic      anyOor;
    logic [afs_pkg::DATA_W-1:0] status;

    // Start pin crossing
    afs_sync2 #(.RST_VAL(1'b1)) uStartSync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (convStartN),
        .syncOut (startS)
    );

    // Bus decode and events
    assign busAct    = !hostBus.csN && (!hostBus.hostReadN || !hostBus.hostWriteN);
    assign readAct   = !hostBus.csN && !hostBus.hostReadN && !hostBus.regSelect;
    assign readDone  = r_q.rdActPrev && !readAct;
    assign push      = (r_q.st == afs_pkg::ST_WRQ) && (r_q.phase == afs_pkg::PHASE_LAST);
    assign startFall = r_q.prevStart && !startS;
    assign startRise = !r_q.prevStart && startS;
    assign fcn       = (r_q.count == 4'h0) ? 3'h0 : 3'(r_q.count - 4'h1);

    // Out-of-range summary over valid entries
    always_comb begin
        anyOor = 1'b0;
        for (int i = 0; i < afs_pkg::QUEUE_DEPTH; i++) begin
            if (4'(i) < r_q.count) begin
                anyOor = anyOor | r_q.queue[i].oor;
            end
        end
    end

    // Status word
    always_comb begin
        status = '0;
        status[afs_pkg::ST_ALFL]                        = r_q.alflN;
        status[afs_pkg::ST_AFC_LO+2:afs_pkg::ST_AFC_LO] = r_q.afc;
        status[afs_pkg::ST_ENAF]                        = r_q.enaf;
        status[afs_pkg::ST_OVR]                         = r_q.ovr;
        status[afs_pkg::ST_OOR]                         = anyOor;
        status[afs_pkg::ST_EMPTY]                       = (r_q.count == 4'h0);
        status[afs_pkg::ST_SOOR]                        = r_q.queue[0].oor;
        status[2:0]                                     = fcn;
    end

    // Next-state logic
    always_comb begin
        r_d           = r_q;
        r_d.prevStart = startS;
        r_d.rdActPrev = readAct;
        // Start handshake and conversion sequence
        if (startFall) begin
            r_d.st    = afs_pkg::ST_ACK;
            r_d.busyN = 1'b0;
        end else if (startRise) begin
            r_d.st     = afs_pkg::ST_REL;
            r_d.hold   = 1'b1;
            r_d.phase  = 2'h0;
            r_d.bitIdx = 4'h0;
            r_d.sar    = afs_pkg::SAR_START;
        end else begin
            case (r_q.st)
                afs_pkg::ST_IDLE: begin
                end
                afs_pkg::ST_ACK: begin
                end
                afs_pkg::ST_REL: begin
                    r_d.busyN = 1'b1;
                    r_d.st    = afs_pkg::ST_CONV;
                    r_d.phase = afs_pkg::PHASE_REL;
                end
                afs_pkg::ST_CONV: begin
                    if (r_q.phase != afs_pkg::PHASE_LAST) begin
                        r_d.phase = r_q.phase + 2'h1;
                    end else if (busAct) begin
                        r_d.phase = afs_pkg::PHASE_LAST;
                    end else if (r_q.bitIdx < 4'(afs_pkg::NUM_BITS)) begin
                        if (!compBit) begin
                            r_d.sar[4'd11 - r_q.bitIdx] = 1'b0;
                        end
                        if (r_q.bitIdx != 4'd11) begin
                            r_d.sar[4'd10 - r_q.bitIdx] = 1'b1;
                        end
                        r_d.bitIdx = r_q.bitIdx + 4'h1;
                        r_d.phase  = 2'h0;
                    end else begin
                        r_d.oorBit = compBit;
                        r_d.bitIdx = afs_pkg::LAST_BIT;
                        r_d.st     = afs_pkg::ST_WRQ;
                        r_d.phase  = 2'h0;
                    end
                end
                afs_pkg::ST_WRQ: begin
                    r_d.phase = r_q.phase + 2'h1;
                    if (push) begin
                        r_d.st   = afs_pkg::ST_IDLE;
                        r_d.hold = 1'b0;
                    end
                end
                default: begin
                    r_d.st = afs_pkg::ST_IDLE;
                end
            endcase
        end
        // Queue pop on read completion
        if (readDone && r_q.count != 4'h0) begin
            if (r_q.count > 4'h1) begin
                for (int i = 0; i < afs_pkg::QUEUE_DEPTH - 1; i++) begin
                    r_d.queue[i] = r_q.queue[i+1];
                end
            end
            r_d.count = r_q.count - 4'h1;
        end
        // Queue push at end of conversion
        if (push) begin
            if (r_d.count == afs_pkg::COUNT_FULL) begin
                r_d.ovr = 1'b1;
            end else begin
                r_d.queue[r_d.count[2:0]] = {r_q.oorBit, r_q.sar};
                r_d.count = r_d.count + 4'h1;
            end
            r_d.alflN = !(!r_q.enaf && r_d.count != 4'h0
                          && 3'(r_d.count - 4'h1) == r_q.afc);
        end
        // Control register write
        if (!hostBus.csN && !hostBus.hostWriteN && hostBus.regSelect) begin
            r_d.afc     = hostBus.wrData[afs_pkg::ST_AFC_LO+2:afs_pkg::ST_AFC_LO];
            r_d.enaf    = hostBus.wrData[afs_pkg::ST_ENAF];
            r_d.holdoff = hostBus.wrData[afs_pkg::ST_OOR];
            if (hostBus.wrData[afs_pkg::ST_OVR]) begin
                r_d.afc     = afs_pkg::AFC_RST;
                r_d.enaf    = afs_pkg::ENAF_RST;
                r_d.holdoff = afs_pkg::HOLDOFF_RST;
                r_d.count   = 4'h0;
                r_d.ovr     = 1'b0;
                r_d.alflN   = 1'b1;
            end
        end
        // Read data and driver enable
        r_d.dataOut = hostBus.regSelect ? status : r_q.queue[0].data;
        r_d.dataOe  = !hostBus.csN && !hostBus.hostReadN
                      && (r_q.holdoff || r_q.busyN);
        // Empty flag from the final count, so the pin comes from a flop
        r_d.empty   = (r_d.count == 4'h0);
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_q           <= '0;
            r_q.st        <= afs_pkg::ST_IDLE;
            r_q.busyN     <= 1'b1;
            r_q.prevStart <= 1'b1;
            r_q.alflN     <= 1'b1;
            r_q.sar       <= afs_pkg::SAR_START;
            r_q.empty     <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from flops
    assign busyN          = r_q.busyN;
    assign sampleHold     = r_q.hold;
    assign dacCode        = r_q.sar;
    assign dataOut        = r_q.dataOut;
    assign dataOe         = r_q.dataOe;
    assign queueEmptyFlag = r_q.empty;
    assign almostFullN    = r_q.alflN;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // One undisturbed bit trial, phase by phase
    sequence s_trial;
        r_q.phase == 2'h0 ##1 r_q.phase == 2'h1 ##1 r_q.phase == 2'h2
        ##1 r_q.phase == 2'h3;
    endsequence

    // Start rise followed by three cycles without a new fall
    sequence s_rise_quiet;
        startRise ##1 !startFall [*3];
    endsequence

    // Range decision taken, then three quiet write-slot cycles
    sequence s_last_dec;
        r_q.st == afs_pkg::ST_CONV && r_q.phase == afs_pkg::PHASE_LAST && !busAct
        && r_q.bitIdx == afs_pkg::LAST_BIT && !startFall && !startRise
        ##1 (!startFall && !startRise) [*3];
    endsequence

    a_busy_ack:  assert property (startFall |=> !busyN)
        else $error("busy not low after start fell");
    a_busy_rel:  assert property (startRise |-> ##1 !busyN ##1 busyN)
        else $error("busy not high on second edge after rise");
    a_first_dec: assert property (s_rise_quiet |->
                     r_q.st == afs_pkg::ST_CONV && r_q.phase == afs_pkg::PHASE_LAST)
        else $error("first decision not on fourth edge");
    a_hold_rise: assert property (startRise |=> sampleHold)
        else $error("sampler not in hold after start rose");
    a_defer_bus: assert property (r_q.st == afs_pkg::ST_CONV
                     && r_q.phase == 2'h3 && busAct && !startFall && !startRise
                     |=> r_q.phase == 2'h3 && $stable(r_q.bitIdx))
        else $error("decision not deferred by bus access");
    a_write_slot: assert property (s_last_dec |=> push)
        else $error("queue write not one trial after range decision");
    a_trial_seq: assert property (r_q.st == afs_pkg::ST_CONV
                     && r_q.phase == 2'h3 && !busAct && r_q.bitIdx < 4'hb
                     && !startFall && !startRise |=> s_trial)
        else $error("trial not four clocks");
    a_push_ptr:  assert property (push && !readDone && r_q.count < 4'h8
                     && !(!hostBus.csN && !hostBus.hostWriteN && hostBus.regSelect)
                     |=> r_q.count == $past(r_q.count) + 4'h1)
        else $error("pointer not advanced on push");
    a_read_pop:  assert property (readDone && r_q.count > 4'h1 && !push
                     |=> r_q.queue[0] == $past(r_q.queue[1]))
        else $error("queue not shifted on read");
    a_empty_keep: assert property (readDone && r_q.count <= 4'h1 && !push
                     |=> $stable(r_q.queue[0]))
        else $error("bottom word lost when empty");
    a_full_drop: assert property (push && r_q.count == 4'h8 && !readDone
                     && !(!hostBus.csN && !hostBus.hostWriteN && hostBus.regSelect)
                     |=> $stable(r_q.queue) && r_q.ovr)
        else $error("full queue overwritten");
    a_holdoff:   assert property (!r_q.holdoff && !r_q.busyN |=> !dataOe)
        else $error("drivers on while held off");

endmodule : afs_adc_fifo_sequencer

// [rtl/afs_pkg.sv]
// Shared constants, types and state encodings of the converter sequencer
package afs_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TRIAL_DIV     = 4;
    localparam int TRIAL_NS      = TRIAL_DIV * CLK_PERIOD_NS;

    // Data shape
    localparam int DATA_W        = 12;
    localparam int QUEUE_DEPTH   = 8;
    localparam int NUM_BITS      = 12;

    // Sequencer constants
    localparam logic [1:0]  PHASE_LAST = 2'h3;
    localparam logic [1:0]  PHASE_REL  = 2'h2;
    localparam logic [3:0]  LAST_BIT   = 4'hc;
    localparam logic [11:0] SAR_START  = 12'h800;
    localparam logic [3:0]  COUNT_FULL = 4'h8;

    // Status word bit positions
    localparam int ST_ALFL   = 11;
    localparam int ST_AFC_LO = 8;
    localparam int ST_ENAF   = 7;
    localparam int ST_OVR    = 6;
    localparam int ST_OOR    = 5;
    localparam int ST_EMPTY  = 4;
    localparam int ST_SOOR   = 3;

    // Control reset values
    localparam logic [2:0] AFC_RST     = 3'h0;
    localparam logic       ENAF_RST    = 1'b0;
    localparam logic       HOLDOFF_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACK  = 3'b001,
        ST_REL  = 3'b010,
        ST_CONV = 3'b011,
        ST_WRQ  = 3'b100
    } afs_state_t;

    typedef struct packed {
        logic              oor;
        logic [DATA_W-1:0] data;
    } afs_entry_t;

    typedef struct packed {
        logic              csN;
        logic              hostReadN;
        logic              hostWriteN;
        logic              regSelect;
        logic [DATA_W-1:0] wrData;
    } afs_host_t;

endpackage : afs_pkg

// [rtl/afs_sync2.sv]
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module afs_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level in and out
    input  wire logic asyncIn,
    output logic      syncOut
);

    logic firstQ;

    // Capture stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            firstQ  <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            firstQ  <= asyncIn;
            syncOut <= firstQ;
        end
    end

endmodule : afs_sync2

// [testbench/afs_host_model.sv]
// Host bus model: queue and status reads, control writes, single-cycle strobes
`timescale 1ns/1ps
module afs_host_model (
    // Clock
    input  wire logic                       clk,
    // Read answer
    input  wire logic [afs_pkg::DATA_W-1:0] dataOut,
    input  wire logic                       dataOe,
    // Host bus
    output afs_pkg::afs_host_t              hostBus
);
    // Idle bus at time zero
    initial begin
        hostBus = '{1'b1, 1'b1, 1'b1, 1'b0, 12'h000};
    end

    // Read held over two edges, answer taken after the first
    task automatic rd(input logic sel, output logic [11:0] d, output logic oe);
        @(posedge clk);
        hostBus.csN       <= 1'b0;
        hostBus.hostReadN <= 1'b0;
        hostBus.regSelect <= sel;
        @(posedge clk);
        #1;
        d  = dataOut;
        oe = dataOe;
        @(posedge clk);
        hostBus.csN       <= 1'b1;
        hostBus.hostReadN <= 1'b1;
        @(posedge clk);
    endtask : rd

    // One-cycle status read, called right at an edge
    task automatic pulse();
        hostBus.csN       <= 1'b0;
        hostBus.hostReadN <= 1'b0;
        hostBus.regSelect <= 1'b1;
        @(posedge clk);
        hostBus.csN       <= 1'b1;
        hostBus.hostReadN <= 1'b1;
    endtask : pulse

    // Control write, data lines inverted once released
    task automatic wr(input logic [11:0] v);
        @(posedge clk);
        hostBus.csN        <= 1'b0;
        hostBus.hostWriteN <= 1'b0;
        hostBus.regSelect  <= 1'b1;
        hostBus.wrData     <= v;
        @(posedge clk);
        hostBus.csN        <= 1'b1;
        hostBus.hostWriteN <= 1'b1;
        hostBus.wrData     <= ~v;
        @(posedge clk);
    endtask : wr
endmodule : afs_host_model

// [testbench/adc_fifo_sequencer_test.sv]
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
module adc_fifo_sequencer_test;
    typedef struct { logic [11:0] vin; logic defer; int expLen; } afs_row_t;

    logic               clk, rst, convStartN, compBit, busyN, sampleHold;
    logic               dataOe, queueEmptyFlag, almostFullN;
    logic [11:0]        dacCode, dataOut, vin, d;
    logic               oe;
    afs_pkg::afs_host_t hostBus;
    int                 num_errors, checks_done, len;
    // Rows: input, deferral, edges from busy release (two edges into trial one) to write
    afs_row_t           rows [8] = '{'{12'h000, 1'b0, 54}, '{12'hfff, 1'b1, 55},
        '{12'h5a3, 1'b0, 54}, '{12'ha5c, 1'b1, 55}, '{12'h001, 1'b0, 54},
        '{12'h800, 1'b1, 55}, '{12'h7ff, 1'b0, 54}, '{12'h3c9, 1'b1, 55}};

    afs_adc_fifo_sequencer u_afs_adc_fifo_sequencer (.clk(clk), .rst(rst),
        .convStartN(convStartN), .compBit(compBit), .hostBus(hostBus), .busyN(busyN),
        .sampleHold(sampleHold), .dacCode(dacCode), .dataOut(dataOut), .dataOe(dataOe),
        .queueEmptyFlag(queueEmptyFlag), .almostFullN(almostFullN));
    afs_host_model u_afs_host_model (.clk(clk), .dataOut(dataOut), .dataOe(dataOe),
        .hostBus(hostBus));

    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Comparator: keep the trial bit while input is at or above it
    always @(posedge clk) begin
        compBit <= (dacCode <= vin);
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Bounded wait for busyN (0) or sampleHold (1) to reach a level
    task automatic wait_for(input int which, input logic v, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((which ? sampleHold : busyN) !== v && n < lim);
        if ((which ? sampleHold : busyN) !== v) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time,
                     (which ? sampleHold : busyN), v);
            tally_and_finish();
        end
    endtask : wait_for

    // One conversion; returns edges from busy release to queue write
    task automatic convert(input logic [11:0] v, input logic defer, input logic busyRd,
                           input logic expOe, output int n);
        int m;
        vin = v;
        @(posedge clk);
        convStartN <= 1'b0;
        wait_for(0, 1'b0, 5, m);
        if (busyRd) begin
            u_afs_host_model.rd(1'b1, d, oe);
            chk({15'h0, oe}, {15'h0, expOe});
        end
        @(posedge clk);
        convStartN <= 1'b1;
        wait_for(0, 1'b1, 6, m);
        chk({15'h0, sampleHold}, 16'h0001);
        n = 0;
        if (defer) begin
            @(posedge clk);
            u_afs_host_model.pulse();
            n = 2;
        end
        wait_for(1, 1'b0, 100, m);
        n += m;
    endtask : convert

    // Main sequence
    initial begin
        rst         = 1'b1;
        convStartN  = 1'b1;
        vin         = 12'h000;
        num_errors  = 0;
        checks_done = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({busyN, sampleHold, dataOe, queueEmptyFlag, dacCode}, 16'h9800);
        foreach (rows[i]) begin
            convert(rows[i].vin, rows[i].defer, i == 0, 1'b0, len);
            chk(16'(len), 16'(rows[i].expLen));
            chk({15'h0, almostFullN}, {15'h0, i != 0});
        end
        u_afs_host_model.wr(12'h020);
        convert(12'h777, 1'b0, 1'b1, 1'b1, len);
        chk(16'(len), 16'd54);
        u_afs_host_model.rd(1'b1, d, oe);
        chk({15'h0, d[afs_pkg::ST_OVR]}, 16'h0001);
        chk({13'h0, d[2:0]}, 16'h0007);
        foreach (rows[i]) begin
            u_afs_host_model.rd(1'b0, d, oe);
            chk({4'h0, d}, {4'h0, rows[i].vin});
        end
        u_afs_host_model.rd(1'b0, d, oe);
        chk({4'h0, d}, {4'h0, rows[7].vin});
        chk({15'h0, queueEmptyFlag}, 16'h0001);
        u_afs_host_model.rd(1'b1, d, oe);
        chk({15'h0, d[afs_pkg::ST_EMPTY]}, 16'h0001);
        u_afs_host_model.wr(12'h040);
        u_afs_host_model.rd(1'b1, d, oe);
        chk({15'h0, d[afs_pkg::ST_OVR]}, 16'h0000);
        tally_and_finish();
    end
endmodule : adc_fifo_sequencer_test
